// ### design/async_parallel_display_port.sv
`include "apdp_params.svh"

// How it works
// - Four generators each make a control level usable on any control pin except the write pin in 68k-style mode.
// - A generator is asserted from its assert point up to its release point.
// - Each pin's generator binding is taken afresh at the start of every access.
// - Both 80-style and 68k-style protocols are served in every mode.
// - Chip select, write strobe, read strobe and register select carry each access.
// - Each access lasts its programmed access size, size zero one cycle; kinds may differ.
// - Apart from the single access gap and wait, no pause is added beyond what sizes and control points give.
// - No fixed setup or hold; controls switch wherever programmed.
// - Single access mode keeps all controls inactive one cycle after each access.
// - The port reacts to a wait change two clock cycles later.
// - Under wait the current access finishes and the next one is held back.
// - Each control pin's polarity is selectable; active low is nominal.
// - Read, address-write and data-write use their own access sizes.
// - Register select and chip select follow their own assert and release points.
// - Read strobe follows its own assert and release points; the write strobe does so in 80-style mode only.
// - Read data is sampled at the read point given with the read request.
// - Burst length is no setting; it follows from successive accesses.
module async_parallel_display_port #(
  parameter int GEN_N = `APDP_GEN_COUNT,
  parameter int ACC_W = `APDP_ACC_W,
  parameter int DATA_W = `APDP_DATA_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration
  input wire display_port_pkg::bus_protocol_t bus_protocol,
  input wire logic single_access_mode,
  input wire logic port_enable,
  input wire display_port_pkg::control_pins_t control_polarity_setting,
  input wire logic [ACC_W-1:0] read_access_size,
  input wire logic [ACC_W-1:0] addr_write_access_size,
  input wire logic [ACC_W-1:0] data_write_access_size,
  input wire logic [GEN_N-1:0][ACC_W-1:0] gen_assert_point,
  input wire logic [GEN_N-1:0][ACC_W-1:0] gen_release_point,
  // Access request
  input wire logic req_valid,
  output logic req_ready,
  input wire display_port_pkg::access_req_t req,
  input wire logic [ACC_W-1:0] req_read_point,
  input wire logic [DATA_W-1:0] req_write_data,
  // Read return
  output logic [DATA_W-1:0] read_data,
  output logic read_data_valid,
  output logic busy,
  // Display pins
  output logic display_chip_select,
  output logic display_write_strobe,
  output logic display_read_strobe,
  output logic display_register_select,
  output logic [DATA_W-1:0] display_data_out,
  output logic display_data_oe,
  input wire logic [DATA_W-1:0] display_data_in,
  input wire logic display_wait_in
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (GEN_N != `APDP_GEN_COUNT)
    begin : g_bad_gen_count
      $error("generator count must match the two-bit pin binding");
    end
    if (ACC_W < 1 || ACC_W > 16 || DATA_W < 1)
    begin : g_bad_widths
      $error("access or data width out of range");
    end
  endgenerate

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic pick_level(input logic [GEN_N-1:0] lv, input logic [1:0] sel);
    pick_level = lv[sel];
  endfunction

  function automatic logic drive_pin(input logic lv, input logic pol);
    drive_pin = pol ? lv : ~lv;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic wait_meta;
  logic wait_sync;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;

  always_ff @(posedge clock)
  begin
    wait_meta <= display_wait_in;
    wait_sync <= wait_meta;
    data_meta <= display_data_in;
    data_sync <= data_meta;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  display_port_pkg::port_state_t state;
  display_port_pkg::port_state_t next_state;
  display_port_pkg::access_req_t cur_req;
  display_port_pkg::access_req_t next_cur_req;
  logic [ACC_W-1:0] count;
  logic [ACC_W-1:0] next_count;
  logic [ACC_W-1:0] cur_size;
  logic [ACC_W-1:0] next_cur_size;
  logic [ACC_W-1:0] cur_read_point;
  logic [ACC_W-1:0] next_cur_read_point;
  logic [DATA_W-1:0] next_data_out;
  logic [DATA_W-1:0] cur_write_data;
  logic [DATA_W-1:0] next_cur_write_data;
  logic last_cycle;
  logic take;
  logic [ACC_W-1:0] req_size;

  always_comb
  begin
    case (req.kind)
      display_port_pkg::ACC_READ: req_size = read_access_size;
      display_port_pkg::ACC_ADDR_WRITE: req_size = addr_write_access_size;
      default: req_size = data_write_access_size;
    endcase
  end

  // Size zero is served as one cycle
  assign last_cycle = ({1'b0, count} + {{ACC_W{1'b0}}, 1'b1}) >= {1'b0, cur_size};

  always_comb
  begin
    req_ready = 1'b0;
    if (port_enable && !wait_sync)
    begin
      case (state)
        display_port_pkg::ST_IDLE: req_ready = 1'b1;
        display_port_pkg::ST_GAP: req_ready = 1'b1;
        display_port_pkg::ST_ACTIVE: req_ready = last_cycle && !single_access_mode;
        default: req_ready = 1'b0;
      endcase
    end
  end

  assign take = req_valid && req_ready;
  assign busy = (state == display_port_pkg::ST_ACTIVE);

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_cur_req = cur_req;
    next_cur_size = cur_size;
    next_cur_read_point = cur_read_point;
    next_cur_write_data = cur_write_data;
    case (state)
      display_port_pkg::ST_IDLE, display_port_pkg::ST_GAP:
      begin
        next_state = display_port_pkg::ST_IDLE;
      end
      display_port_pkg::ST_ACTIVE:
      begin
        next_count = count + {{(ACC_W-1){1'b0}}, 1'b1};
        if (last_cycle)
        begin
          next_state = single_access_mode ? display_port_pkg::ST_GAP
                                          : display_port_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = display_port_pkg::ST_IDLE;
      end
    endcase
    if (take)
    begin
      next_state = display_port_pkg::ST_ACTIVE;
      next_count = '0;
      next_cur_req = req;
      next_cur_size = req_size;
      next_cur_read_point = req_read_point;
      next_cur_write_data = req_write_data;
    end
    if (reset)
    begin
      next_state = display_port_pkg::ST_IDLE;
      next_count = '0;
      next_cur_req = '0;
      next_cur_size = '0;
      next_cur_read_point = '0;
      next_cur_write_data = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    state <= next_state;
    count <= next_count;
    cur_req <= next_cur_req;
    cur_size <= next_cur_size;
    cur_read_point <= next_cur_read_point;
    cur_write_data <= next_cur_write_data;
  end

  // ----------------------------------------
  // Signal generators
  // ----------------------------------------
  logic [GEN_N-1:0] gen_level;

  generate
    for (genvar g = 0; g < GEN_N; g++)
    begin : g_gen
      assign gen_level[g] = (state == display_port_pkg::ST_ACTIVE)
        && (count >= gen_assert_point[g]) && (count < gen_release_point[g]);
    end
  endgenerate

  // ----------------------------------------
  // Control pins
  // ----------------------------------------
  display_port_pkg::control_pins_t logical;
  display_port_pkg::control_pins_t next_pins;
  logic is_read;
  logic active;
  logic next_oe;

  assign active = (state == display_port_pkg::ST_ACTIVE);
  assign is_read = (cur_req.kind == display_port_pkg::ACC_READ);

  always_comb
  begin
    logical.chip_select = pick_level(gen_level, cur_req.binding.cs_gen);
    logical.register_select = pick_level(gen_level, cur_req.binding.rs_gen);
    if (bus_protocol == display_port_pkg::BUS_68K)
    begin
      // Write pin is the direction line, read pin the enable
      logical.write_strobe = active && !is_read;
      logical.read_strobe = pick_level(gen_level, cur_req.binding.rd_gen);
    end
    else
    begin
      logical.write_strobe = !is_read && pick_level(gen_level, cur_req.binding.wr_gen);
      logical.read_strobe = is_read && pick_level(gen_level, cur_req.binding.rd_gen);
    end
    next_data_out = display_data_out;
    if (active && !is_read)
    begin
      next_data_out = cur_write_data;
    end
    if (reset)
    begin
      logical = '0;
      next_data_out = '0;
    end
    next_pins.chip_select = drive_pin(logical.chip_select,
                                      control_polarity_setting.chip_select);
    next_pins.write_strobe = drive_pin(logical.write_strobe,
                                       control_polarity_setting.write_strobe);
    next_pins.read_strobe = drive_pin(logical.read_strobe,
                                      control_polarity_setting.read_strobe);
    next_pins.register_select = drive_pin(logical.register_select,
                                          control_polarity_setting.register_select);
    next_oe = active && !is_read && !reset;
  end

  always_ff @(posedge clock)
  begin
    display_chip_select <= next_pins.chip_select;
    display_write_strobe <= next_pins.write_strobe;
    display_read_strobe <= next_pins.read_strobe;
    display_register_select <= next_pins.register_select;
    display_data_oe <= next_oe;
    display_data_out <= next_data_out;
  end

  // ----------------------------------------
  // Read sampling
  // ----------------------------------------
  logic sample_now;
  logic [DATA_W-1:0] next_read_data;
  logic next_read_valid;

  // Depends on the display holding data across the read point
  assign sample_now = active && is_read && (count == cur_read_point);

  always_comb
  begin
    next_read_data = read_data;
    next_read_valid = 1'b0;
    if (sample_now)
    begin
      next_read_data = data_sync;
      next_read_valid = 1'b1;
    end
    if (reset)
    begin
      next_read_data = '0;
      next_read_valid = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    read_data <= next_read_data;
    read_data_valid <= next_read_valid;
  end

endmodule

// ### design/apdp_params.svh
`ifndef APDP_PARAMS_SVH
`define APDP_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define APDP_GEN_COUNT 4
`define APDP_ACC_W 8
`define APDP_DATA_W 16

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define APDP_STATE_RESET 2'h0
`define APDP_GAP_CYCLES 1
`define APDP_WAIT_DELAY_CYCLES 2

`endif

// ### design/display_port_pkg.sv
`include "apdp_params.svh"

package display_port_pkg;

  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_ADDR_WRITE = 2'h1,
    ACC_DATA_WRITE = 2'h2
  } access_kind_t;

  typedef enum logic {
    BUS_80 = 1'b0,
    BUS_68K = 1'b1
  } bus_protocol_t;

  // Gray along idle, active, gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_GAP = 2'h3
  } port_state_t;

  typedef struct packed {
    logic [1:0] cs_gen;
    logic [1:0] wr_gen;
    logic [1:0] rd_gen;
    logic [1:0] rs_gen;
  } pin_binding_t;

  typedef struct packed {
    access_kind_t kind;
    pin_binding_t binding;
  } access_req_t;

  typedef struct packed {
    logic chip_select;
    logic write_strobe;
    logic read_strobe;
    logic register_select;
  } control_pins_t;

endpackage

// ### verif/display_port_props.sv
// ----------------------------------------
// Port checks
// ----------------------------------------
module display_port_props (
  // Clock and configuration
  input wire logic clock,
  input wire logic reset,
  input wire logic single_access_mode,
  input wire logic port_enable,
  input wire display_port_pkg::control_pins_t control_polarity_setting,
  // Requests and pins
  input wire logic req_valid,
  input wire logic req_ready,
  input wire display_port_pkg::access_req_t req,
  input wire logic read_data_valid,
  input wire logic busy,
  input wire logic display_chip_select,
  input wire logic display_write_strobe,
  input wire logic display_read_strobe,
  input wire logic display_register_select,
  input wire logic display_data_oe,
  input wire logic display_wait_in
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] pins = {display_chip_select, display_write_strobe, display_read_strobe,
    display_register_select};
  wire [3:0] idle = ~control_polarity_setting;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence take_s;
    req_valid && req_ready;
  endsequence
  sequence idle3_s;
    !busy [*3];
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    reset |=> pins == idle && !display_data_oe && !read_data_valid)
    else $error("outputs not idle after reset");
  a_enable_gate: assert property (!port_enable |-> !req_ready)
    else $error("ready while disabled");
  a_wait_stall: assert property ($past(display_wait_in, 2) |-> !req_ready)
    else $error("ready two cycles into wait");
  a_accept_busy: assert property (take_s |=> busy)
    else $error("accept did not open a window");
  a_write_oe: assert property (take_s ##0 req.kind != 2'h0 |-> ##2 display_data_oe)
    else $error("write window without data drive");
  a_read_no_oe: assert property (take_s ##0 req.kind == 2'h0 |-> ##2 !display_data_oe)
    else $error("read window drives data");
  a_single_gap: assert property (single_access_mode && $fell(busy) |=> pins == idle)
    else $error("no idle cycle after access");
  a_no_self_start: assert property (!busy && !(req_valid && req_ready) |=> !busy)
    else $error("window opened without request");
  a_idle_pins: assert property (idle3_s ##0 $stable(control_polarity_setting)
    |-> pins == idle) else $error("pins active while idle");
  a_valid_in_read: assert property (read_data_valid |-> $past(busy))
    else $error("read sample outside a window");
endmodule
bind async_parallel_display_port display_port_props u_display_port_props (.*);

// ### verif/display_panel_model.sv
module display_panel_model (
  // Clock and pins
  input wire logic clock,
  input wire logic display_read_strobe,
  input wire display_port_pkg::control_pins_t control_polarity_setting,
  // Bench control
  input wire logic [15:0] reply_word,
  input wire logic stall,
  // Returned pins
  output logic [15:0] display_data_in,
  output logic display_wait_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last = 16'h0000;
  always @(posedge clock) last <= display_data_in;
  // Drives while read strobe active, else a changing pattern
  assign display_data_in = (display_read_strobe == control_polarity_setting.read_strobe)
    ? reply_word : ~last;
  assign display_wait_in = stall;
endmodule

// ### verif/tb_async_parallel_display_port.sv
module tb_async_parallel_display_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  display_port_pkg::bus_protocol_t bus_protocol = display_port_pkg::BUS_80;
  logic single_access_mode = 1'b0;
  logic port_enable = 1'b1;
  logic req_valid = 1'b0;
  logic stall = 1'b0;
  logic read_data_valid, busy, req_ready, display_data_oe, display_wait_in;
  logic display_chip_select, display_write_strobe, display_read_strobe, display_register_select;
  display_port_pkg::control_pins_t pol = 4'h0, pol_d = 4'h0;
  display_port_pkg::access_req_t req = '0;
  logic [7:0] read_access_size = 8'h05, addr_write_access_size = 8'h01;
  logic [7:0] data_write_access_size = 8'h01, req_read_point = 8'h00;
  logic [3:0][7:0] gen_assert_point = '0, gen_release_point = '0;
  logic [15:0] req_write_data = 16'h0000, reply = 16'h0000;
  logic [15:0] read_data, display_data_out, display_data_in;
  logic [3:0] pins;
  logic [20:0] exp_q[$];
  logic [20:0] e;
  logic wr_acc;
  logic [15:0] held = 16'h0000;
  logic [15:0] rd_q[$];
  int errors = 0, cmp_count = 0, sz;
  int unsigned seed = 43883;
  always #5 clock = ~clock;
  always @(posedge clock) pol_d <= pol;
  assign pins = {display_chip_select, display_write_strobe, display_read_strobe,
    display_register_select};
  async_parallel_display_port u_async_parallel_display_port (.control_polarity_setting(pol), .*);
  display_panel_model u_display_panel_model (.control_polarity_setting(pol), .reply_word(reply),
    .*);
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic lv(logic [1:0] g, int k);
    return k >= gen_assert_point[g] && k < gen_release_point[g];
  endfunction
  function automatic logic [3:0] pins_at(int k);
    logic w;
    logic [3:0] a;
    w = req.kind != display_port_pkg::ACC_READ;
    a[3] = lv(req.binding.cs_gen, k);
    a[2] = bus_protocol == display_port_pkg::BUS_80 ? w && lv(req.binding.wr_gen, k) : w;
    a[1] = (bus_protocol == display_port_pkg::BUS_68K || !w) && lv(req.binding.rd_gen, k);
    a[0] = lv(req.binding.rs_gen, k);
    return ~(a ^ pol);
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  // ----------------------------------------
  // Pin and read model
  // ----------------------------------------
  always @(negedge clock)
  begin
    if (!reset)
    begin
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        check("pins", 16'(pins), 16'(e[3:0]));
      end
      else
      begin
        e = {1'b0, held, 4'(~pol_d)};
        check("idle pins", 16'(pins), 16'(e[3:0]));
      end
      check("data out", display_data_out, e[19:4]);
      check("data enable", 16'(display_data_oe), 16'(e[20]));
      if (read_data_valid)
        check("read data", read_data, rd_q.size() ? rd_q.pop_front() : 'x);
      if (req_valid && req_ready)
      begin
        if (single_access_mode) check("gap", 16'(exp_q.size()), 16'h0000);
        while (exp_q.size() < 1) exp_q.push_back({1'b0, held, 4'(~pol)});
        wr_acc = req.kind != display_port_pkg::ACC_READ;
        if (wr_acc) held = req_write_data;
        sz = req.kind == display_port_pkg::ACC_READ ? read_access_size :
          req.kind == display_port_pkg::ACC_ADDR_WRITE ? addr_write_access_size :
          data_write_access_size;
        for (int k = 0; k < (sz == 0 ? 1 : sz); k++)
          exp_q.push_back({wr_acc, held, pins_at(k)});
        if (req.kind == display_port_pkg::ACC_READ && req_read_point < sz) rd_q.push_back(reply);
      end
    end
  end
  task automatic send(display_port_pkg::access_kind_t k);
    req.kind = k;
    req.binding = {2'(rnd()), 2'(rnd()), 2'h3, 2'(rnd())};
    req_write_data = 16'(rnd());
    req_valid = 1'b1;
    repeat (100) if (req_ready !== 1'b1) @(negedge clock);
    check("ready", 16'(req_ready), 16'h0001);
    @(posedge clock);
    #1;
  endtask
  task automatic group(int n);
    bus_protocol = display_port_pkg::bus_protocol_t'(1'(rnd()));
    single_access_mode = 1'(rnd());
    pol = 4'(rnd());
    read_access_size = 8'h05 + 8'(rnd() % 4);
    addr_write_access_size = 8'(rnd() % 6);
    data_write_access_size = 8'h01 + 8'(rnd() % 7);
    req_read_point = read_access_size - 8'(rnd() % 2);
    for (int g = 0; g < 3; g++)
    begin
      gen_assert_point[g] = 8'(rnd() % 6);
      gen_release_point[g] = 8'(rnd() % 8);
    end
    gen_assert_point[3] = 8'h00;
    gen_release_point[3] = 8'hff;
    reply = 16'(rnd());
    for (int i = 0; i < n; i++) send(display_port_pkg::access_kind_t'(2'(rnd() % 3)));
    req_valid = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    $display("group of %0d done", n);
  endtask
  task automatic stop_test();
    check("reads left", 16'(rd_q.size()), 16'h0000);
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #200us;
    errors++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
    port_enable = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("disabled", 16'({req_ready, busy}), 16'h0000);
    port_enable = 1'b1;
    for (int t = 0; t < 40; t++) group(6);
    fork
      begin
        repeat (4) @(posedge clock);
        #1 stall = 1'b1;
        repeat (6) @(posedge clock);
        #1 stall = 1'b0;
      end
    join_none
    group(8);
    stall = 1'b1;
    repeat (3) @(posedge clock);
    #1 req_valid = 1'b1;
    repeat (5) @(posedge clock);
    #1 check("held by wait", 16'({req_ready, busy}), 16'h0000);
    stall = 1'b0;
    group(1);
    stop_test();
  end
endmodule
